// file: common/vmc_regs.svh
`ifndef VMC_REGS_SVH
`define VMC_REGS_SVH

// Register offsets
`define VMC_OFF_VOLT_FIRST   8'h20
`define VMC_OFF_VOLT_LAST    8'h24
`define VMC_OFF_REMOTE1_TEMP 8'h25
`define VMC_OFF_LOCAL_TEMP   8'h26
`define VMC_OFF_REMOTE2_TEMP 8'h27
`define VMC_OFF_STATUS_TWO   8'h42
`define VMC_OFF_CODE         8'h43
`define VMC_OFF_FAN1_MIN_HI  8'h55
`define VMC_OFF_REMOTE1_OFS  8'h70
`define VMC_OFF_LOCAL_OFS    8'h71
`define VMC_OFF_REMOTE2_OFS  8'h72
`define VMC_OFF_CONFIG_TWO   8'h73
`define VMC_OFF_IRQ_MASK_TWO 8'h75
`define VMC_OFF_TEMP_FRAC    8'h77

// Field positions
`define VMC_CODE_SIXTH_BIT   5
`define VMC_CODE_INPUT_THRESHOLD_SELECT_BIT    6
`define VMC_CODE_SEL_BIT     7
`define VMC_STAT_FLAG_BIT    0
`define VMC_MASK_FLAG_BIT    0
`define VMC_CFG_AVG_OFF_BIT  4
`define VMC_CFG_BYPASS_BIT   5
`define VMC_CFG_SINGLE_BIT   6
`define VMC_CHSEL_MSB        7
`define VMC_CHSEL_LSB        5

// Reset values
`define VMC_RST_TEMP         8'h80
`define VMC_RST_FRAC         8'h00
`define VMC_RST_VOLT         8'h00
`define VMC_RST_CODE_CTRL    2'h0
`define VMC_RST_FAN1_MIN_HI  8'hFF
`define VMC_RST_OFFSET       8'h00
`define VMC_RST_CONFIG_TWO   8'h00
`define VMC_RST_IRQ_MASK_TWO 8'h00

// Timing, in ns, and the clock period
`define VMC_CLK_PERIOD_NS    8
`define VMC_CODE_WINDOW_NS   11000
`define VMC_VOLT_CONV_NS     711000
`define VMC_REMOTE_MEAS_NS   25500000
`define VMC_LOCAL_MEAS_NS    12000000
`define VMC_AVG_COUNT        16

`endif

// file: common/vmc_pkg.sv
package vmc_pkg;

    typedef enum logic [2:0] {
        VMC_BUS_IDLE = 3'b000,
        VMC_BUS_ADDR = 3'b001,
        VMC_BUS_PTR  = 3'b010,
        VMC_BUS_WR   = 3'b011,
        VMC_BUS_RD   = 3'b100,
        VMC_BUS_SKIP = 3'b101
    } vmc_bus_e;

    typedef enum logic [1:0] {
        VMC_SEQ_PACE = 2'b00,
        VMC_SEQ_CONV = 2'b01
    } vmc_seq_e;

    typedef logic [2:0] vmc_chan_t;
    typedef logic [9:0] vmc_res_t;

endpackage : vmc_pkg

// file: common/vmc_code_if.sv
`timescale 1ns/1ns
interface vmc_code_if;
    logic [5:0] level;
    logic       change;
    logic       use6;

    modport watch (input use6, output level, output change);
    modport core  (input level, input change, output use6);
endinterface : vmc_code_if

// file: design/vmc_code_watch.sv
`timescale 1ns/1ns
`include "vmc_regs.svh"
module vmc_code_watch import vmc_pkg::*; #(
    parameter int WINDOW_CYC = `VMC_CODE_WINDOW_NS / `VMC_CLK_PERIOD_NS
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    input  wire logic [5:0] i_code_pin,
    vmc_code_if.watch       code
);
    logic [5:0]  meta_r;
    logic [5:0]  sync_r;
    logic [5:0]  prev_r;
    logic [15:0] win_cnt_r;
    logic        chg_r;
    logic [5:0]  mask;

    assign mask = code.use6 ? 6'h3F : 6'h1F;
    assign code.level  = sync_r;
    assign code.change = chg_r;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= 6'h00;
            sync_r <= 6'h00;
        end else begin
            meta_r <= i_code_pin;
            sync_r <= meta_r;
        end
    end

    // Pattern compared with the one taken one window earlier
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            win_cnt_r <= 16'h0000;
            prev_r    <= 6'h00;
            chg_r     <= 1'b0;
        end else if (win_cnt_r == 16'(WINDOW_CYC - 1)) begin
            win_cnt_r <= 16'h0000;
            prev_r    <= sync_r;
            chg_r     <= code.use6 && ((sync_r & mask) != (prev_r & mask));
        end else begin
            win_cnt_r <= win_cnt_r + 16'h0001;
            chg_r     <= 1'b0;
        end
    end
endmodule : vmc_code_watch

// file: design/vmc_top.sv
// Functional notes
// - Code register bits 0-4 show the five dedicated code input levels.
// - Bit 5 reads zero in 12 V mode, else the shared pin level.
// - Bit 6 is a writable threshold select: 0 nominal, 1 reduced.
// - Bit 7 selects shared pin role: 0 = 12 V input, 1 = sixth code.
// - In 12 V mode status bit 0 reports 12 V out-of-limit results.
// - In code mode status bit 0 sets when pattern differs from one window ago.
// - Code change drives the alert unless mask bit 0 is set.
// - Voltage results average 16 conversions; config bit 4 stores single ones.
// - Config bit 5 drives the attenuator bypass control.
// - Config bit 6 holds conversion on the selected channel only.
// - Fan1 minimum high bits 7:5 choose the single-mode channel.
// - Local temperature register holds upper eight result bits.
// - Temperatures are 10-bit two's complement in quarter degree steps.
// - Remote results average 16 cycles, each measurement paced at 25.5 ms / 16.
// - Two fraction bits per temperature go to the fraction register.
// - Channel offset, quarter degree steps, is added before storing.
// - The three offset registers reset to zero.
// - Reading fraction register freezes temperatures until all are read.
`timescale 1ns/1ns
`include "vmc_regs.svh"
module vmc_top import vmc_pkg::*; #(
    parameter logic [6:0] DEV_ADDR    = 7'h2E, // Arbitrary bus address
    parameter int         VOLT_CYC    = `VMC_VOLT_CONV_NS / `VMC_CLK_PERIOD_NS,
    parameter int         REMOTE_CYC  = `VMC_REMOTE_MEAS_NS / `VMC_CLK_PERIOD_NS / `VMC_AVG_COUNT,
    parameter int         LOCAL_CYC   = `VMC_LOCAL_MEAS_NS / `VMC_CLK_PERIOD_NS / `VMC_AVG_COUNT,
    parameter int         WINDOW_CYC  = `VMC_CODE_WINDOW_NS / `VMC_CLK_PERIOD_NS
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    output logic            o_alert_n_out,
    output logic            o_alert_oe,
    input  wire logic [5:0] i_code_pin,
    input  wire logic       i_12v_out_of_limit,
    output logic            o_adc_start,
    output logic [2:0]      o_adc_chan,
    input  wire logic       i_conv_valid,
    input  wire logic [9:0] i_conv_data,
    output logic            o_avg_off,
    output logic            o_atten_bypass,
    output logic            o_single_chan,
    output logic            o_threshold_low,
    output logic            o_pin_as_code
);
    vmc_code_if code ();

    vmc_code_watch #(.WINDOW_CYC(WINDOW_CYC)) u_watch (
        .i_sys_clk  (i_sys_clk),
        .i_nrst     (i_nrst),
        .i_code_pin (i_code_pin),
        .code       (code)
    );

    logic [1:0]  code_ctrl_r;
    logic [7:0]  fan1_hi_r;
    logic [7:0]  ofs_r [5:7];
    logic [7:0]  cfg2_r;
    logic [7:0]  mask2_r;
    logic        flag_r;
    logic [7:0]  vol_r [0:4];
    vmc_res_t    live_r [5:7];
    vmc_res_t    vis_r [5:7];
    logic        freeze_r;
    logic [2:0]  seen_r;

    logic [1:0]  scl_meta_r, sda_meta_r;
    logic        scl_r, sda_r, scl_d_r, sda_d_r;
    vmc_bus_e    bus_st_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [7:0]  tx_r;
    logic [7:0]  ptr_r;
    logic        ack_r;
    logic        rnw_r;
    logic        oe_r;
    logic        wr_stb_r;
    logic [7:0]  wr_data_r;
    logic        rd_stb;
    logic [7:0]  rd_data;

    logic        scl_rise, scl_fall, start_c, stop_c;

    assign code.use6       = code_ctrl_r[1];
    assign o_sda_out       = 1'b0;
    assign o_sda_oe        = oe_r;
    assign o_alert_n_out   = 1'b0;
    assign o_avg_off       = cfg2_r[`VMC_CFG_AVG_OFF_BIT];
    assign o_atten_bypass  = cfg2_r[`VMC_CFG_BYPASS_BIT];
    assign o_single_chan   = cfg2_r[`VMC_CFG_SINGLE_BIT];
    assign o_threshold_low = code_ctrl_r[0];
    assign o_pin_as_code   = code_ctrl_r[1];

    // Serial bus pins: two-flop synchronisers, then edge detection
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            scl_meta_r <= 2'h3;
            sda_meta_r <= 2'h3;
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
        end else begin
            scl_meta_r <= {scl_meta_r[0], i_scl};
            sda_meta_r <= {sda_meta_r[0], i_sda};
            scl_d_r    <= scl_r;
            sda_d_r    <= sda_r;
        end
    end
    assign scl_r    = scl_meta_r[1];
    assign sda_r    = sda_meta_r[1];
    assign scl_rise = scl_r && !scl_d_r;
    assign scl_fall = !scl_r && scl_d_r;
    assign start_c  = scl_r && scl_d_r && sda_d_r && !sda_r;
    assign stop_c   = scl_r && scl_d_r && !sda_d_r && sda_r;

    // Register read mux, fixed by the pointer
    always_comb begin
        rd_data = 8'h00;
        case (ptr_r)
            `VMC_OFF_REMOTE1_TEMP: rd_data = vis_r[5][9:2];
            `VMC_OFF_LOCAL_TEMP:   rd_data = vis_r[6][9:2];
            `VMC_OFF_REMOTE2_TEMP: rd_data = vis_r[7][9:2];
            `VMC_OFF_TEMP_FRAC:    rd_data = {vis_r[7][1:0], vis_r[6][1:0], vis_r[5][1:0], 2'h0};
            `VMC_OFF_STATUS_TWO:   rd_data = {7'h00, flag_r};
            `VMC_OFF_CODE:         rd_data = {code_ctrl_r,
                                              code.level[5] & code_ctrl_r[1],
                                              code.level[4:0]};
            `VMC_OFF_FAN1_MIN_HI:  rd_data = fan1_hi_r;
            `VMC_OFF_REMOTE1_OFS:  rd_data = ofs_r[5];
            `VMC_OFF_LOCAL_OFS:    rd_data = ofs_r[6];
            `VMC_OFF_REMOTE2_OFS:  rd_data = ofs_r[7];
            `VMC_OFF_CONFIG_TWO:   rd_data = cfg2_r;
            `VMC_OFF_IRQ_MASK_TWO: rd_data = mask2_r;
            default: begin
                if (ptr_r >= `VMC_OFF_VOLT_FIRST && ptr_r <= `VMC_OFF_VOLT_LAST) begin
                    rd_data = vol_r[3'(ptr_r - `VMC_OFF_VOLT_FIRST)];
                end
            end
        endcase
    end

    // A byte is fetched for transmit at the fall that ends an ack slot
    assign rd_stb = scl_fall && ack_r && !start_c && !stop_c &&
                    ((bus_st_r == VMC_BUS_ADDR && rnw_r) || (bus_st_r == VMC_BUS_RD));

    // Serial bus slave: address, pointer, write data, read data
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_st_r  <= VMC_BUS_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            tx_r      <= 8'h00;
            ptr_r     <= 8'h00;
            ack_r     <= 1'b0;
            rnw_r     <= 1'b0;
            oe_r      <= 1'b0;
            wr_stb_r  <= 1'b0;
            wr_data_r <= 8'h00;
        end else begin
            wr_stb_r <= 1'b0;
            if (start_c) begin
                bus_st_r  <= VMC_BUS_ADDR;
                bit_cnt_r <= 4'h0;
                ack_r     <= 1'b0;
                oe_r      <= 1'b0;
            end else if (stop_c) begin
                bus_st_r <= VMC_BUS_IDLE;
                ack_r    <= 1'b0;
                oe_r     <= 1'b0;
            end else if (scl_rise) begin
                if (ack_r) begin
                    if (bus_st_r == VMC_BUS_RD && sda_r) begin
                        bus_st_r <= VMC_BUS_SKIP;
                        ack_r    <= 1'b0;
                    end
                end else if (bus_st_r == VMC_BUS_ADDR || bus_st_r == VMC_BUS_PTR ||
                             bus_st_r == VMC_BUS_WR) begin
                    shift_r   <= {shift_r[6:0], sda_r};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end else if (bus_st_r == VMC_BUS_RD) begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
            end else if (scl_fall) begin
                if (ack_r) begin
                    ack_r     <= 1'b0;
                    oe_r      <= 1'b0;
                    bit_cnt_r <= 4'h0;
                    case (bus_st_r)
                        VMC_BUS_ADDR: begin
                            if (rnw_r) begin
                                bus_st_r <= VMC_BUS_RD;
                                oe_r     <= !rd_data[7];
                                tx_r     <= {rd_data[6:0], 1'b1};
                            end else begin
                                bus_st_r <= VMC_BUS_PTR;
                            end
                        end
                        VMC_BUS_PTR: bus_st_r <= VMC_BUS_WR;
                        VMC_BUS_RD: begin
                            oe_r <= !rd_data[7];
                            tx_r <= {rd_data[6:0], 1'b1};
                        end
                        default: bus_st_r <= bus_st_r;
                    endcase
                end else if (bus_st_r == VMC_BUS_RD) begin
                    if (bit_cnt_r == 4'h8) begin
                        oe_r      <= 1'b0;
                        ack_r     <= 1'b1;
                        bit_cnt_r <= 4'h0;
                    end else begin
                        oe_r <= !tx_r[7];
                        tx_r <= {tx_r[6:0], 1'b1};
                    end
                end else if (bit_cnt_r == 4'h8) begin
                    bit_cnt_r <= 4'h0;
                    case (bus_st_r)
                        VMC_BUS_ADDR: begin
                            if (shift_r[7:1] == DEV_ADDR) begin
                                rnw_r <= shift_r[0];
                                ack_r <= 1'b1;
                                oe_r  <= 1'b1;
                            end else begin
                                bus_st_r <= VMC_BUS_SKIP;
                            end
                        end
                        VMC_BUS_PTR: begin
                            ptr_r <= shift_r;
                            ack_r <= 1'b1;
                            oe_r  <= 1'b1;
                        end
                        VMC_BUS_WR: begin
                            wr_stb_r  <= 1'b1;
                            wr_data_r <= shift_r;
                            ack_r     <= 1'b1;
                            oe_r      <= 1'b1;
                        end
                        default: bus_st_r <= bus_st_r;
                    endcase
                end
            end
        end
    end

    // Writable registers
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            code_ctrl_r <= `VMC_RST_CODE_CTRL;
            fan1_hi_r   <= `VMC_RST_FAN1_MIN_HI;
            cfg2_r      <= `VMC_RST_CONFIG_TWO;
            mask2_r     <= `VMC_RST_IRQ_MASK_TWO;
            for (int i = 5; i <= 7; i++) begin
                ofs_r[i] <= `VMC_RST_OFFSET;
            end
        end else if (wr_stb_r) begin
            case (ptr_r)
                `VMC_OFF_CODE:         code_ctrl_r <= wr_data_r[`VMC_CODE_SEL_BIT:`VMC_CODE_INPUT_THRESHOLD_SELECT_BIT];
                `VMC_OFF_FAN1_MIN_HI:  fan1_hi_r   <= wr_data_r;
                `VMC_OFF_REMOTE1_OFS:  ofs_r[5]    <= wr_data_r;
                `VMC_OFF_LOCAL_OFS:    ofs_r[6]    <= wr_data_r;
                `VMC_OFF_REMOTE2_OFS:  ofs_r[7]    <= wr_data_r;
                `VMC_OFF_CONFIG_TWO:   cfg2_r      <= wr_data_r;
                `VMC_OFF_IRQ_MASK_TWO: mask2_r     <= wr_data_r;
                default:               cfg2_r      <= cfg2_r;
            endcase
        end
    end

    // Status flag and alert; a new event wins over the clear-on-read
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flag_r     <= 1'b0;
            o_alert_oe <= 1'b0;
        end else begin
            if ((code_ctrl_r[1] && code.change) ||
                (!code_ctrl_r[1] && i_12v_out_of_limit)) begin
                flag_r <= 1'b1;
            end else if (rd_stb && ptr_r == `VMC_OFF_STATUS_TWO) begin
                flag_r <= 1'b0;
            end
            o_alert_oe <= flag_r && !mask2_r[`VMC_MASK_FLAG_BIT];
        end
    end

    // Freeze of temperature readouts between fraction read and all temperature reads
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            freeze_r <= 1'b0;
            seen_r   <= 3'h0;
            for (int i = 5; i <= 7; i++) begin
                vis_r[i] <= {`VMC_RST_TEMP, 2'h0};
            end
        end else begin
            if (rd_stb && ptr_r == `VMC_OFF_TEMP_FRAC) begin
                freeze_r <= 1'b1;
                seen_r   <= 3'h0;
            end else if (freeze_r && rd_stb) begin
                if (ptr_r >= `VMC_OFF_REMOTE1_TEMP && ptr_r <= `VMC_OFF_REMOTE2_TEMP) begin
                    seen_r[2'(ptr_r - `VMC_OFF_REMOTE1_TEMP)] <= 1'b1;
                end
            end else if (freeze_r && seen_r == 3'h7) begin
                freeze_r <= 1'b0;
            end
            if (!freeze_r && !(rd_stb && ptr_r == `VMC_OFF_TEMP_FRAC)) begin
                for (int i = 5; i <= 7; i++) begin
                    vis_r[i] <= live_r[i];
                end
            end
        end
    end

    // Conversion sequencer with averaging and offset correction
    vmc_seq_e    seq_st_r;
    vmc_chan_t   chan_r;
    logic [19:0] pace_r;
    logic [3:0]  n_r;
    logic [14:0] acc_r;
    logic [14:0] sample_x;
    logic [14:0] sum_x;
    logic [9:0]  avg_x;
    logic [10:0] corr_x;
    vmc_res_t    temp_x;
    vmc_chan_t   sel_x;
    vmc_chan_t   next_chan;
    logic        last_x;
    logic [19:0] period_x;

    assign sel_x     = fan1_hi_r[`VMC_CHSEL_MSB:`VMC_CHSEL_LSB];
    assign next_chan = o_single_chan ? sel_x : vmc_chan_t'(chan_r + 3'h1);
    assign sample_x  = chan_r[2] && (chan_r != 3'h4) ? {{5{i_conv_data[9]}}, i_conv_data}
                                                     : {5'h00, i_conv_data};
    assign sum_x     = acc_r + sample_x;
    assign last_x    = o_avg_off || (n_r == 4'(`VMC_AVG_COUNT - 1));
    assign avg_x     = o_avg_off ? i_conv_data : sum_x[13:4];
    assign corr_x    = {avg_x[9], avg_x} + {{3{ofs_r[chan_r][7]}}, ofs_r[chan_r]};
    assign temp_x    = (corr_x[10] != corr_x[9]) ? {corr_x[10], {9{!corr_x[10]}}} : corr_x[9:0];

    always_comb begin
        case (next_chan)
            3'h5, 3'h7: period_x = 20'(REMOTE_CYC - 1);
            3'h6:       period_x = 20'(LOCAL_CYC - 1);
            default:    period_x = 20'(VOLT_CYC - 1);
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            seq_st_r    <= VMC_SEQ_PACE;
            chan_r      <= 3'h0;
            pace_r      <= 20'h0_0000;
            n_r         <= 4'h0;
            acc_r       <= 15'h0000;
            o_adc_start <= 1'b0;
            o_adc_chan  <= 3'h0;
            for (int i = 0; i <= 4; i++) begin
                vol_r[i] <= `VMC_RST_VOLT;
            end
            for (int i = 5; i <= 7; i++) begin
                live_r[i] <= {`VMC_RST_TEMP, 2'h0};
            end
        end else begin
            o_adc_start <= 1'b0;
            case (seq_st_r)
                VMC_SEQ_PACE: begin
                    if (pace_r == 20'h0_0000) begin
                        o_adc_start <= 1'b1;
                        o_adc_chan  <= chan_r;
                        seq_st_r    <= VMC_SEQ_CONV;
                    end else begin
                        pace_r <= pace_r - 20'h0_0001;
                    end
                end
                VMC_SEQ_CONV: begin
                    if (i_conv_valid) begin
                        seq_st_r <= VMC_SEQ_PACE;
                        if (last_x) begin
                            if (chan_r[2] && chan_r != 3'h4) begin
                                live_r[chan_r] <= temp_x;
                            end else if (chan_r <= 3'h4) begin
                                vol_r[chan_r] <= avg_x[9:2];
                            end
                            acc_r  <= 15'h0000;
                            n_r    <= 4'h0;
                            chan_r <= next_chan;
                            pace_r <= period_x;
                        end else begin
                            acc_r  <= sum_x;
                            n_r    <= n_r + 4'h1;
                            pace_r <= (chan_r == 3'h5 || chan_r == 3'h7) ? 20'(REMOTE_CYC - 1) :
                                      (chan_r == 3'h6) ? 20'(LOCAL_CYC - 1) : 20'(VOLT_CYC - 1);
                        end
                    end
                end
                default: seq_st_r <= VMC_SEQ_PACE;
            endcase
        end
    end
endmodule : vmc_top

// file: sim/vmc_host.sv
`timescale 1ns/1ns
module vmc_host import vmc_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h2E
) (
    input  wire logic i_sys_clk,
    input  wire logic i_sda,
    output logic       o_scl,
    output logic       o_pull,
    output logic       o_done,
    output logic [7:0] o_data
);
    initial begin
        o_scl  = 1'b1;
        o_pull = 1'b0;
        o_done = 1'b0;
        o_data = 8'h00;
    end
    task automatic w(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : w
    // Start (a = 0) or stop (a = 1): data set while the clock is low, then toggled while it is high
    task automatic frame(input logic a);
        o_scl <= 1'b0;
        w(4);
        o_pull <= a;
        w(4);
        o_scl <= 1'b1;
        w(8);
        o_pull <= !a;
        w(8);
    endtask : frame
    // Eight bits and the acknowledge slot, data changed in mid low phase
    task automatic b9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            o_scl <= 1'b0;
            w(4);
            o_pull <= !tx[i];
            w(4);
            o_scl <= 1'b1;
            w(8);
            rx[i] = i_sda;
        end
    endtask : b9
    task automatic xfer(input logic [7:0] p, input logic [7:0] d, input logic rd);
        logic [8:0] r;
        frame(1'b0);
        b9({DEV_ADDR, 2'b01}, r);
        b9({p, 1'b1}, r);
        if (rd) begin
            frame(1'b0);
            b9({DEV_ADDR, 2'b11}, r);
        end
        b9(rd ? 9'h1FF : {d, 1'b1}, r);
        frame(1'b1);
        o_data <= r[8:1];
        o_done <= rd;
        w(1);
        o_done <= 1'b0;
    endtask : xfer
endmodule : vmc_host

// file: sim/vmc_top_props.sv
`timescale 1ns/1ns
module vmc_top_props import vmc_pkg::*; (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_scl,
    input wire logic o_sda_oe,
    input wire logic o_alert_oe,
    input wire logic o_adc_start,
    input wire logic o_avg_off,
    input wire logic o_atten_bypass,
    input wire logic o_single_chan,
    input wire logic o_threshold_low,
    input wire logic o_pin_as_code
);
    logic [7:0] quiet_r;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    // Cycles since the device last pulled the data line
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst)
            quiet_r <= 8'h00;
        else
            quiet_r <= o_sda_oe ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hFF};
    end
    property p_gap; o_adc_start |=> !o_adc_start [*8]; endproperty
    a_gap: assert property (p_gap) else $error("start pulses too close");
    property p_sda; $changed(o_sda_oe) |-> !i_scl; endproperty
    a_sda: assert property (p_sda) else $error("data drive moved with clock high");
    property p_input_threshold_select; $changed(o_threshold_low) |-> ##[0:8] o_sda_oe; endproperty
    a_input_threshold_select: assert property (p_input_threshold_select) else $error("threshold moved without write");
    property p_pin; $changed(o_pin_as_code) |-> ##[0:8] o_sda_oe; endproperty
    a_pin: assert property (p_pin) else $error("pin role moved without write");
    property p_avg; $changed(o_avg_off) |-> ##[0:8] o_sda_oe; endproperty
    a_avg: assert property (p_avg) else $error("averaging moved without write");
    property p_byp; $changed(o_atten_bypass) |-> ##[0:8] o_sda_oe; endproperty
    a_byp: assert property (p_byp) else $error("bypass moved without write");
    property p_one; $changed(o_single_chan) |-> ##[0:8] o_sda_oe; endproperty
    a_one: assert property (p_one) else $error("single mode moved without write");
    property p_clr; $fell(o_alert_oe) |-> quiet_r < 8'hC8; endproperty
    a_clr: assert property (p_clr) else $error("alert dropped without access");
endmodule : vmc_top_props
bind vmc_top vmc_top_props chk_u (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_scl(i_scl), .o_sda_oe(o_sda_oe),
    .o_alert_oe(o_alert_oe), .o_adc_start(o_adc_start), .o_avg_off(o_avg_off), .o_atten_bypass(o_atten_bypass),
    .o_single_chan(o_single_chan), .o_threshold_low(o_threshold_low), .o_pin_as_code(o_pin_as_code));

// file: sim/vmc_top_tb.sv
`timescale 1ns/1ns
module vmc_top_tb import vmc_pkg::*; ;
    logic        sys_clk = 1'b0, nrst = 1'b0, v12 = 1'b0, conv_valid = 1'b0;
    logic [9:0]  conv_data = 10'h000;
    logic [5:0]  code;
    logic [2:0]  vsr = 3'h0, adc_chan;
    logic [15:0] q[$], me;
    logic        scl, pull, sda, sda_oe, alert_oe, adc_start, avg_off, bypass, single, input_threshold_select, pin_code, done;
    logic [7:0]  rdata;
    logic        sda_out, alert_n_out, alert_n;
    integer      seed = 32'hacb3;
    int          bad_count = 0, total_checks = 0;
    always #4 sys_clk = ~sys_clk;
    assign sda = !(pull | (sda_oe & !sda_out));
    assign alert_n = !(alert_oe & !alert_n_out);
    vmc_top #(.VOLT_CYC(20), .REMOTE_CYC(30), .LOCAL_CYC(25), .WINDOW_CYC(16)) dut_u (
        .i_sys_clk(sys_clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .o_alert_n_out(alert_n_out), .o_alert_oe(alert_oe), .i_code_pin(code), .i_12v_out_of_limit(v12),
        .o_adc_start(adc_start), .o_adc_chan(adc_chan), .i_conv_valid(conv_valid), .i_conv_data(conv_data),
        .o_avg_off(avg_off), .o_atten_bypass(bypass), .o_single_chan(single), .o_threshold_low(input_threshold_select),
        .o_pin_as_code(pin_code));
    vmc_host host_u (.i_sys_clk(sys_clk), .i_sda(sda), .o_scl(scl), .o_pull(pull), .o_done(done), .o_data(rdata));
    // Converter answers four cycles after each start; temperatures fixed at 50.25 degrees
    always @(posedge sys_clk) begin
        vsr        <= {vsr[1:0], adc_start};
        conv_valid <= vsr[2];
        conv_data  <= (adc_chan > 3'h4) ? 10'h0C9 : 10'($random(seed));
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] p, input logic [7:0] m, input logic [7:0] e);
        q.push_back({m, e});
        host_u.xfer(p, 8'h00, 1'b1);
    endtask : rchk
    always @(posedge sys_clk) begin
        if (done) begin
            me = q.pop_front();
            chk("read", rdata & me[15:8], me[7:0]);
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end
    initial begin
        code <= 6'($random(seed));
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        host_u.w(4);
        rchk(8'h26, 8'hFF, 8'h80);
        for (int i = 0; i < 3; i++) rchk(8'h70 + 8'(i), 8'hFF, 8'h00);
        rchk(8'h43, 8'hFF, {3'h0, code[4:0]});
        host_u.xfer(8'h71, 8'h05, 1'b0);
        host_u.xfer(8'h43, 8'hC0, 1'b0);
        chk("role", {6'h00, pin_code, input_threshold_select}, 8'h03);
        rchk(8'h43, 8'hFF, {2'b11, code});
        code <= code ^ 6'h21;
        host_u.w(60);
        chk("alert", {7'h00, alert_n}, 8'h00);
        rchk(8'h42, 8'h01, 8'h01);
        rchk(8'h42, 8'h01, 8'h00);
        host_u.xfer(8'h75, 8'h01, 1'b0);
        code <= code ^ 6'h02;
        host_u.w(60);
        chk("alert", {7'h00, alert_n}, 8'h01);
        rchk(8'h42, 8'h01, 8'h01);
        host_u.xfer(8'h43, 8'h00, 1'b0);
        code <= code ^ 6'h20;
        host_u.w(60);
        rchk(8'h42, 8'h01, 8'h00);
        v12 <= 1'b1;
        host_u.w(1);
        v12 <= 1'b0;
        rchk(8'h42, 8'h01, 8'h01);
        host_u.w(3000);
        rchk(8'h77, 8'hFC, 8'h64);
        rchk(8'h26, 8'hFF, 8'h33);
        rchk(8'h25, 8'hFF, 8'h32);
        rchk(8'h27, 8'hFF, 8'h32);
        host_u.xfer(8'h55, 8'h80, 1'b0);
        host_u.xfer(8'h73, 8'h70, 1'b0);
        chk("config", {5'h00, single, bypass, avg_off}, 8'h07);
        host_u.w(600);
        @(posedge sys_clk iff adc_start);
        chk("channel", {5'h00, adc_chan}, 8'h04);
        summarize();
    end
endmodule : vmc_top_tb
